//--- src/pkg_thermal_defs.svh
// Purpose: Offsets, field positions and reset values of the package thermal registers.
// Assumes: Registers are selected by a small register index on the register port.
// Notes:   Definitions only.
`ifndef PKG_THERMAL_DEFS_SVH
`define PKG_THERMAL_DEFS_SVH

// -----------------------------------------------------------------------------
// Register indices
// -----------------------------------------------------------------------------
`define REG_PKG_STATUS      3'h0
`define REG_PKG_INTR_CTRL   3'h1
`define REG_CORE_STATUS     3'h2
`define REG_CORE_INTR_CTRL  3'h3
`define REG_CAPABILITY      3'h4

// -----------------------------------------------------------------------------
// Status fields
// -----------------------------------------------------------------------------
`define ST_HOT              0
`define ST_HOT_LOG          1
`define ST_EXT_EVT          2
`define ST_EXT_LOG          3
`define ST_CRIT             4
`define ST_CRIT_LOG         5
`define ST_THR1             6
`define ST_THR1_LOG         7
`define ST_THR2             8
`define ST_THR2_LOG         9
`define ST_PWR_LIM          10
`define ST_PWR_LOG          11
`define ST_READOUT_LO       16
`define ST_READOUT_HI       22
`define ST_VALID            31

// -----------------------------------------------------------------------------
// Interrupt control fields
// -----------------------------------------------------------------------------
`define IC_HIGH_EN          0
`define IC_LOW_EN           1
`define IC_EXT_EN           2
`define IC_CRIT_EN          4
`define IC_THR1_LO          8
`define IC_THR1_HI          14
`define IC_THR1_EN          15
`define IC_THR2_LO          16
`define IC_THR2_HI          22
`define IC_THR2_EN          23
`define IC_PWR_EN           24

// Bits of the interrupt control word that software may write.
`define IC_WRITE_MASK       64'h0000_0000_01FF_FF17
`define IC_RESET            64'h0000_0000_0000_0000

// -----------------------------------------------------------------------------
// Capability word fields
// -----------------------------------------------------------------------------
`define CAP_PWR_NOTIFY      4
`define CAP_PKG_THERMAL     6

`endif

//--- src/pkg_thermal_pkg.sv
// Purpose: Types shared by the package thermal register bank.
// Assumes: Nothing.
// Notes:   Field positions live in the defs header.
package pkg_thermal_pkg;
    typedef logic [63:0] reg_word_t;
    typedef logic [6:0]  readout_t;
    typedef logic [2:0]  reg_index_t;
endpackage

//--- src/thermal_edge_unit.sv
// Purpose: Edge detector and sticky log for one thermal condition.
// Assumes: Condition input is synchronous to the clock.
// Notes:   A new rising edge wins over a software clear in the same cycle.
`timescale 1ns/1ps
module thermal_edge_unit (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic cond,
    input  wire logic clear,
    output logic      level,
    output logic      rise,
    output logic      fall,
    output logic      log_bit
);
    logic prev;
    logic next_prev;
    logic next_log;

    always_comb begin
        next_prev = cond;
        next_log  = log_bit;
        if (clear) begin
            next_log = 1'b0;
        end
        if (cond && !prev) begin
            next_log = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prev    <= 1'b0;
            log_bit <= 1'b0;
        end else begin
            prev    <= next_prev;
            log_bit <= next_log;
        end
    end

    assign level = prev;
    assign rise  = cond && !prev;
    assign fall  = !cond && prev;
endmodule

//--- src/pkg_thermal_regs.sv
// Operation
// RQ1 - Live high-temperature status bit, read-only
// RQ2 - High-temperature log sets, clears on zero write
// RQ3 - External throttle event bit plus sticky log
// RQ4 - Critical temperature status plus sticky log
// RQ5 - Threshold one status when readout reaches threshold
// RQ6 - Threshold two status and sticky log
// RQ7 - Power limitation status while limit forces throttling
// RQ8 - Power notification log sets on any throttle
// RQ9 - Seven-bit readout below activation, zero hottest
// RQ10 - High-temperature enable interrupts on rising heat
// RQ11 - Low-temperature enable interrupts on cooling down
// RQ12 - External throttle interrupt needs bidirectional feature
// RQ13 - Critical temperature enable raises interrupt
// RQ14 - Threshold one value compared with readout
// RQ15 - Threshold one interrupt on either crossing
// RQ16 - Threshold two value compared with readout
// RQ17 - Threshold two interrupt on either crossing
// RQ18 - Package power notification enable raises event
// RQ19 - Core power notification via thermal entry, enabled
// RQ20 - Capability flags for notification and package facility
// RQ21 - One register instance shared by all cores
// RQ22 - Core readout valid flag reads one when valid
// RQ23 - Writing one to logs keeps them unchanged
// RQ24 - All enabled sources merge into one event
//
// Purpose: Package thermal status and interrupt control registers with core notification bits.
// Assumes: Register port is a simple indexed read/write port; inputs are synchronous.
// Notes:   Thermal event outputs are one-cycle pulses toward the local interrupt controller.
//          Status bits lag their inputs by one clock, threshold bits by two.
//          Register indices 0 to 4 select the five views; other indices read as zero.
`timescale 1ns/1ps
`include "pkg_thermal_defs.svh"

module pkg_thermal_regs
    import pkg_thermal_pkg::*;
#(
    parameter int READOUT_W = 7
) (
    input  wire logic     CORE_CLK,
    input  wire logic     SRST,
    input  wire logic     REG_WR,
    input  wire logic     REG_RD,
    input  wire reg_index_t REG_INDEX,
    input  wire reg_word_t  REG_WDATA,
    output reg_word_t     REG_RDATA,
    output logic          REG_RVALID,
    input  wire logic     SENSOR_HOT,
    input  wire logic     EXT_THROTTLE,
    input  wire logic     BIDIR_THROTTLE_EN,
    input  wire logic     SENSOR_CRIT,
    input  wire logic     PKG_POWER_LIMITED,
    input  wire logic     CORE_POWER_LIMITED,
    input  wire readout_t SENSOR_READOUT,
    input  wire logic     SENSOR_VALID,
    output logic          PKG_THERMAL_EVENT,
    output logic          CORE_THERMAL_EVENT
);
    // -------------------------------------------------------------------------
    // Register storage
    // -------------------------------------------------------------------------
    reg_word_t pkg_ctrl;
    reg_word_t next_pkg_ctrl;
    reg_word_t core_ctrl;
    reg_word_t next_core_ctrl;
    readout_t  readout;
    readout_t  next_readout;
    logic      readout_valid;
    logic      next_readout_valid;
    logic      wr_pkg_status;
    logic      wr_pkg_ctrl;
    logic      wr_core_status;
    logic      wr_core_ctrl;

    function automatic logic log_clear(input logic sel, input reg_word_t wd, input int bitpos);
        log_clear = sel && !wd[bitpos];
    endfunction

    // Capability flags are fixed: both facilities are always present.
    function automatic reg_word_t capability_word();
        reg_word_t w;
        w = '0;
        w[`CAP_PWR_NOTIFY]  = 1'b1;   // [RQ20]
        w[`CAP_PKG_THERMAL] = 1'b1;
        return w;
    endfunction

    // -------------------------------------------------------------------------
    // Write decode
    // -------------------------------------------------------------------------
    // A write strobe reaches one register only; an unmapped index is dropped.
    always_comb begin
        wr_pkg_status  = REG_WR && (REG_INDEX == `REG_PKG_STATUS);
        wr_pkg_ctrl    = REG_WR && (REG_INDEX == `REG_PKG_INTR_CTRL);
        wr_core_status = REG_WR && (REG_INDEX == `REG_CORE_STATUS);
        wr_core_ctrl   = REG_WR && (REG_INDEX == `REG_CORE_INTR_CTRL);
    end

    // -------------------------------------------------------------------------
    // Condition tracking
    // -------------------------------------------------------------------------
    localparam int NCOND = 7;
    logic [NCOND-1:0] cond;
    logic [NCOND-1:0] clr;
    logic [NCOND-1:0] lvl;
    logic [NCOND-1:0] rise;
    logic [NCOND-1:0] fall;
    logic [NCOND-1:0] lg;
    logic             thr1_hit;
    logic             thr2_hit;
    logic             core_lim_lvl;
    logic             core_lim_rise;
    logic             core_lim_fall;
    logic             core_lim_log;
    logic             core_lim_clr;

    // Lower readout means hotter, so reaching a threshold is readout <= value.
    // An invalid reading never counts as a threshold hit.
    assign thr1_hit = readout_valid &&
                      (readout <= pkg_ctrl[`IC_THR1_HI:`IC_THR1_LO]);  // [RQ5] [RQ14]
    assign thr2_hit = readout_valid &&
                      (readout <= pkg_ctrl[`IC_THR2_HI:`IC_THR2_LO]);  // [RQ6] [RQ16]

    always_comb begin
        cond[0] = SENSOR_HOT;                          // [RQ1]
        cond[1] = EXT_THROTTLE;                        // [RQ3]
        cond[2] = SENSOR_CRIT;                         // [RQ4]
        cond[3] = thr1_hit;                            // [RQ5]
        cond[4] = thr2_hit;                            // [RQ6]
        cond[5] = PKG_POWER_LIMITED;                   // [RQ7]
        cond[6] = PKG_POWER_LIMITED || CORE_POWER_LIMITED; // [RQ8]
        clr[0] = log_clear(wr_pkg_status, REG_WDATA, `ST_HOT_LOG); // [RQ2] [RQ23]
        clr[1] = log_clear(wr_pkg_status, REG_WDATA, `ST_EXT_LOG);
        clr[2] = log_clear(wr_pkg_status, REG_WDATA, `ST_CRIT_LOG);
        clr[3] = log_clear(wr_pkg_status, REG_WDATA, `ST_THR1_LOG);
        clr[4] = log_clear(wr_pkg_status, REG_WDATA, `ST_THR2_LOG);
        clr[5] = 1'b0;
        clr[6] = log_clear(wr_pkg_status, REG_WDATA, `ST_PWR_LOG);
    end

    assign core_lim_clr = log_clear(wr_core_status, REG_WDATA, `ST_PWR_LOG);

    // Each condition has its own edge detector and sticky log.
    // A rise in the cycle of a clearing write keeps the log set, so no event is lost.
    genvar g;
    generate
        for (g = 0; g < NCOND; g++) begin : g_cond
            thermal_edge_unit u_edge (
                .clk     (CORE_CLK),
                .srst    (SRST),
                .cond    (cond[g]),
                .clear   (clr[g]),
                .level   (lvl[g]),
                .rise    (rise[g]),
                .fall    (fall[g]),
                .log_bit (lg[g])
            );
        end
    endgenerate

    thermal_edge_unit u_core_lim (
        .clk     (CORE_CLK),
        .srst    (SRST),
        .cond    (CORE_POWER_LIMITED),
        .clear   (core_lim_clr),
        .level   (core_lim_lvl),
        .rise    (core_lim_rise),
        .fall    (core_lim_fall),
        .log_bit (core_lim_log)
    );

    // -------------------------------------------------------------------------
    // Control registers and readout capture
    // -------------------------------------------------------------------------
    // Reserved positions of a control write are dropped by the mask.
    always_comb begin
        next_pkg_ctrl      = pkg_ctrl;
        next_core_ctrl     = core_ctrl;
        next_readout       = SENSOR_READOUT;        // [RQ9]
        next_readout_valid = SENSOR_VALID;          // [RQ22]
        if (wr_pkg_ctrl) begin
            next_pkg_ctrl = REG_WDATA & `IC_WRITE_MASK;
        end
        if (wr_core_ctrl) begin
            next_core_ctrl = REG_WDATA & `IC_WRITE_MASK;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            pkg_ctrl      <= `IC_RESET;             // [RQ10] [RQ11]
            core_ctrl     <= `IC_RESET;
            readout       <= 7'h00;
            readout_valid <= 1'b0;
        end else begin
            pkg_ctrl      <= next_pkg_ctrl;
            core_ctrl     <= next_core_ctrl;
            readout       <= next_readout;          // [RQ9]
            readout_valid <= next_readout_valid;    // [RQ22]
        end
    end

    // -------------------------------------------------------------------------
    // Event generation
    // -------------------------------------------------------------------------
    // Sources are gated edges of the tracked conditions. The merged event is
    // registered, so it pulses one clock after the edge is seen at the input.
    logic [6:0] evt_src;
    logic       next_pkg_event;
    logic       next_core_event;

    always_comb begin
        evt_src[0]      = pkg_ctrl[`IC_HIGH_EN] && rise[0];                      // [RQ10]
        evt_src[1]      = pkg_ctrl[`IC_LOW_EN] && fall[0];                       // [RQ11]
        evt_src[2]      = pkg_ctrl[`IC_EXT_EN] && BIDIR_THROTTLE_EN && rise[1];  // [RQ12]
        evt_src[3]      = pkg_ctrl[`IC_CRIT_EN] && rise[2];                      // [RQ13]
        evt_src[4]      = pkg_ctrl[`IC_THR1_EN] && (rise[3] || fall[3]);         // [RQ15]
        evt_src[5]      = pkg_ctrl[`IC_THR2_EN] && (rise[4] || fall[4]);         // [RQ17]
        evt_src[6]      = pkg_ctrl[`IC_PWR_EN] && rise[6];                       // [RQ18]
        next_pkg_event  = |evt_src;                                              // [RQ24]
        next_core_event = core_ctrl[`IC_PWR_EN] && core_lim_rise;                // [RQ19]
    end

    // -------------------------------------------------------------------------
    // Read path
    // -------------------------------------------------------------------------
    reg_word_t next_rdata;
    logic      next_rvalid;
    reg_word_t pkg_status;
    reg_word_t core_status;

    // -------------------------------------------------------------------------
    // Status views
    // -------------------------------------------------------------------------
    always_comb begin
        pkg_status = '0;
        pkg_status[`ST_HOT]      = lvl[0];          // [RQ1]
        pkg_status[`ST_HOT_LOG]  = lg[0];           // [RQ2]
        pkg_status[`ST_EXT_EVT]  = lvl[1];          // [RQ3]
        pkg_status[`ST_EXT_LOG]  = lg[1];
        pkg_status[`ST_CRIT]     = lvl[2];          // [RQ4]
        pkg_status[`ST_CRIT_LOG] = lg[2];
        pkg_status[`ST_THR1]     = lvl[3];
        pkg_status[`ST_THR1_LOG] = lg[3];
        pkg_status[`ST_THR2]     = lvl[4];
        pkg_status[`ST_THR2_LOG] = lg[4];
        pkg_status[`ST_PWR_LIM]  = lvl[5];          // [RQ7]
        pkg_status[`ST_PWR_LOG]  = lg[6];           // [RQ8]
        pkg_status[`ST_READOUT_HI:`ST_READOUT_LO] = readout; // [RQ9]
    end

    always_comb begin
        core_status = '0;
        core_status[`ST_PWR_LIM] = core_lim_lvl;    // [RQ19]
        core_status[`ST_PWR_LOG] = core_lim_log;
        core_status[`ST_READOUT_HI:`ST_READOUT_LO] = readout;
        core_status[`ST_VALID]   = readout_valid;   // [RQ22]
    end

    always_comb begin
        next_rvalid = REG_RD;
        next_rdata  = REG_RDATA;
        if (REG_RD) begin
            case (REG_INDEX)
                `REG_PKG_STATUS:     next_rdata = pkg_status;
                `REG_PKG_INTR_CTRL:  next_rdata = pkg_ctrl;
                `REG_CORE_STATUS:    next_rdata = core_status;
                `REG_CORE_INTR_CTRL: next_rdata = core_ctrl;
                `REG_CAPABILITY:     next_rdata = capability_word(); // [RQ20]
                default:             next_rdata = '0;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Output registers
    // -------------------------------------------------------------------------
    // One bank serves every core of the package; cores share this port. [RQ21]
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            REG_RDATA          <= 64'h0;
            REG_RVALID         <= 1'b0;
            PKG_THERMAL_EVENT  <= 1'b0;
            CORE_THERMAL_EVENT <= 1'b0;
        end else begin
            REG_RDATA          <= next_rdata;
            REG_RVALID         <= next_rvalid;
            PKG_THERMAL_EVENT  <= next_pkg_event;
            CORE_THERMAL_EVENT <= next_core_event;
        end
    end

    // -------------------------------------------------------------------------
    // Unused edge outputs
    // -------------------------------------------------------------------------
    logic unused_ok;
    assign unused_ok = &{1'b0, core_lim_fall, fall[6:5], fall[2:1], rise[5]};
endmodule

//--- tb/pkg_thermal_regs_assertions.sv
// Purpose: Port-level checks of the package thermal register bank.
// Assumes: Only the top module's ports are visible.
// Notes:   Bound into every instance of the bank.
`timescale 1ns/1ps
`include "pkg_thermal_defs.svh"
module pkg_thermal_regs_checker
    import pkg_thermal_pkg::*;
#(
    parameter int READOUT_W = 7
) (
    input wire logic       CORE_CLK,
    input wire logic       SRST,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire reg_index_t REG_INDEX,
    input wire reg_word_t  REG_WDATA,
    input wire reg_word_t  REG_RDATA,
    input wire logic       REG_RVALID,
    input wire logic       SENSOR_HOT,
    input wire logic       EXT_THROTTLE,
    input wire logic       BIDIR_THROTTLE_EN,
    input wire logic       SENSOR_CRIT,
    input wire logic       PKG_POWER_LIMITED,
    input wire logic       CORE_POWER_LIMITED,
    input wire readout_t   SENSOR_READOUT,
    input wire logic       SENSOR_VALID,
    input wire logic       PKG_THERMAL_EVENT,
    input wire logic       CORE_THERMAL_EVENT
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);

    // Shadow of the interrupt enables, so an event can be traced to an enable.
    reg_word_t ctrl_shadow;
    reg_word_t next_ctrl_shadow;
    always_comb begin
        next_ctrl_shadow = ctrl_shadow;
        if (REG_WR && REG_INDEX == `REG_PKG_INTR_CTRL)
            next_ctrl_shadow = REG_WDATA & `IC_WRITE_MASK;
    end
    always_ff @(posedge CORE_CLK) begin
        ctrl_shadow <= SRST ? `IC_RESET : next_ctrl_shadow;
    end

    a_read_answer: assert property (REG_RD |=> REG_RVALID)
        else $error("read strobe not answered");
    a_hot_live: assert property ((SENSOR_HOT [*3] ##0 (REG_RD && REG_INDEX == `REG_PKG_STATUS))
        |=> REG_RDATA[`ST_HOT]) else $error("hot status not shown");
    a_crit_quiet: assert property ((!SENSOR_CRIT [*3] ##0 (REG_RD && REG_INDEX == `REG_PKG_STATUS))
        |=> !REG_RDATA[`ST_CRIT]) else $error("critical status without cause");
    a_readout_field: assert property (((SENSOR_VALID && $stable(SENSOR_READOUT)) [*3]
        ##0 (REG_RD && REG_INDEX == `REG_PKG_STATUS)) |=> REG_RDATA[22:16] == $past(SENSOR_READOUT))
        else $error("readout field wrong");
    a_ctrl_readback: assert property (((REG_WR && REG_INDEX == `REG_PKG_INTR_CTRL) ##1 !REG_WR
        ##1 (REG_RD && !REG_WR && REG_INDEX == `REG_PKG_INTR_CTRL))
        |=> REG_RDATA == ($past(REG_WDATA, 3) & `IC_WRITE_MASK)) else $error("control readback wrong");
    a_unmapped_zero: assert property ((REG_RD && REG_INDEX > `REG_CAPABILITY) |=> REG_RDATA == 64'h0)
        else $error("unmapped read not zero");
    a_capability_flags: assert property ((REG_RD && REG_INDEX == `REG_CAPABILITY)
        |=> REG_RDATA[`CAP_PWR_NOTIFY] && REG_RDATA[`CAP_PKG_THERMAL]) else $error("capability flags low");
    a_event_enabled: assert property (PKG_THERMAL_EVENT
        |-> ($past(ctrl_shadow) & 64'h0000_0000_0180_8017) != 64'h0)
        else $error("event with no enable set");
endmodule

bind pkg_thermal_regs pkg_thermal_regs_checker #(.READOUT_W(READOUT_W)) i_pkg_thermal_regs_checker (
    .CORE_CLK, .SRST, .REG_WR, .REG_RD, .REG_INDEX, .REG_WDATA, .REG_RDATA, .REG_RVALID, .SENSOR_HOT,
    .EXT_THROTTLE, .BIDIR_THROTTLE_EN, .SENSOR_CRIT, .PKG_POWER_LIMITED, .CORE_POWER_LIMITED,
    .SENSOR_READOUT, .SENSOR_VALID, .PKG_THERMAL_EVENT, .CORE_THERMAL_EVENT
);

//--- tb/thermal_partner.sv
// Purpose: Thermal sensor and local interrupt controller seen by the bank.
// Assumes: Requests change at a falling edge by non-blocking assignment.
// Notes:   Sensor levels follow requests one falling edge later; events are counted.
`timescale 1ns/1ps
module thermal_partner (
    input  wire logic       clk,
    input  wire logic [4:0] src_req,
    input  wire logic [6:0] readout_req,
    input  wire logic       valid_req,
    input  wire logic       pkg_event,
    input  wire logic       core_event,
    output logic [4:0]      src,
    output logic [6:0]      readout,
    output logic            valid,
    output int              pkg_count,
    output int              core_count
);
    initial begin
        src = 5'h00;
        readout = 7'h7F;
        valid = 1'b0;
        pkg_count = 0;
        core_count = 0;
    end
    always @(negedge clk) begin
        src <= src_req;
        readout <= readout_req;
        valid <= valid_req;
    end
    always @(posedge clk) begin
        if (pkg_event === 1'b1)
            pkg_count <= pkg_count + 1;
        if (core_event === 1'b1)
            core_count <= core_count + 1;
    end
endmodule

//--- tb/package_thermal_status_interrupt_tb_top.sv
// Purpose: Self-checking bench for the package thermal register bank.
// Assumes: Inputs change at the falling edge; read data is taken one cycle after the strobe.
// Notes:   Event counts come from the partner model.
`timescale 1ns/1ps
`include "pkg_thermal_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module package_thermal_status_interrupt_tb_top;
    import pkg_thermal_pkg::*;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       bidir = 1'b0;
    logic       valid_req = 1'b0;
    logic [4:0] src_req = 5'h00;
    logic [4:0] sen;
    reg_index_t idx = 3'h0;
    reg_word_t  wdata = 64'h0;
    reg_word_t  rdata;
    readout_t   readout_req = 7'h7F;
    readout_t   sen_readout;
    logic       rvalid, pkg_ev, core_ev, sen_valid;
    int         pkg_count, core_count;
    int         mismatches = 0;
    int         checked = 0;
    always #2 clk = ~clk;

    pkg_thermal_regs i_pkg_thermal_regs (.CORE_CLK(clk), .SRST(srst), .REG_WR(wr), .REG_RD(rd), .REG_INDEX(idx),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .SENSOR_HOT(sen[0]), .EXT_THROTTLE(sen[1]),
        .BIDIR_THROTTLE_EN(bidir), .SENSOR_CRIT(sen[2]), .PKG_POWER_LIMITED(sen[3]), .CORE_POWER_LIMITED(sen[4]),
        .SENSOR_READOUT(sen_readout), .SENSOR_VALID(sen_valid), .PKG_THERMAL_EVENT(pkg_ev),
        .CORE_THERMAL_EVENT(core_ev));
    thermal_partner i_thermal_partner (.clk(clk), .src_req(src_req), .readout_req(readout_req),
        .valid_req(valid_req), .pkg_event(pkg_ev), .core_event(core_ev), .src(sen), .readout(sen_readout),
        .valid(sen_valid), .pkg_count(pkg_count), .core_count(core_count));

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr_reg(input reg_index_t i, input reg_word_t d);
        @(negedge clk);
        wr = 1'b1;
        idx = i;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input reg_index_t i, input reg_word_t e, input reg_word_t m);
        @(negedge clk);
        rd = 1'b1;
        idx = i;
        @(negedge clk);
        rd = 1'b0;
        `CHK(rvalid, 1'b1)
        `CHK(rdata & m, e & m)
    endtask
    // Raises one condition, drops it, then shows the log surviving ones and clearing on zeros.
    task automatic log_check(input int s, input int p);
        src_req[s] <= 1'b1;
        idle(4);
        rd_reg(`REG_PKG_STATUS, 64'h3 << p, 64'h3 << p);
        src_req[s] <= 1'b0;
        idle(4);
        rd_reg(`REG_PKG_STATUS, 64'h2 << p, 64'h3 << p);
        wr_reg(`REG_PKG_STATUS, 64'hFFFF_FFFF_FFFF_FFFF);
        rd_reg(`REG_PKG_STATUS, 64'h2 << p, 64'h2 << p);
        wr_reg(`REG_PKG_STATUS, 64'h0);
        rd_reg(`REG_PKG_STATUS, 64'h0, 64'h2 << p);
    endtask
    task automatic ev(input reg_word_t pc, input reg_word_t cc, input int s, input logic v, input int ep,
                      input int ec);
        int p0;
        int c0;
        wr_reg(`REG_PKG_INTR_CTRL, pc);
        wr_reg(`REG_CORE_INTR_CTRL, cc);
        p0 = pkg_count;
        c0 = core_count;
        src_req[s] <= v;
        idle(6);
        `CHK(pkg_count - p0, ep)
        `CHK(core_count - c0, ec)
    endtask
    task automatic thr(input int r, input reg_word_t s, input int e);
        int p0;
        p0 = pkg_count;
        readout_req <= r[6:0];
        idle(6);
        `CHK(pkg_count - p0, e)
        rd_reg(`REG_PKG_STATUS, (64'(r) << 16) | s, 64'h7F_03C0);
    endtask
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #20000;
        mismatches++;
        print_verdict();
    end

    initial begin
        repeat (2) @(negedge clk);
        srst = 1'b0;
        rd_reg(`REG_PKG_INTR_CTRL, `IC_RESET, 64'hFFFF_FFFF_FFFF_FFFF);
        rd_reg(`REG_PKG_STATUS, 64'h0, 64'hFFFF_FFFF_FF80_FFFF);
        rd_reg(`REG_CAPABILITY, 64'h50, 64'h50);
        rd_reg(`REG_CORE_STATUS, 64'h0, 64'h8000_0000);
        for (int i = 5; i < 8; i++)
            rd_reg(reg_index_t'(i), 64'h0, 64'hFFFF_FFFF_FFFF_FFFF);
        wr_reg(`REG_PKG_INTR_CTRL, 64'hFFFF_FFFF_FFFF_FFFF);
        rd_reg(`REG_PKG_INTR_CTRL, `IC_WRITE_MASK, 64'hFFFF_FFFF_FFFF_FFFF);
        wr_reg(`REG_PKG_INTR_CTRL, 64'h0);
        wr_reg(`REG_CORE_INTR_CTRL, 64'hFFFF_FFFF_FFFF_FFFF);
        rd_reg(`REG_CORE_INTR_CTRL, `IC_WRITE_MASK, 64'hFFFF_FFFF_FFFF_FFFF);
        wr_reg(`REG_CORE_INTR_CTRL, 64'h0);
        $display("test registers done");
        log_check(0, `ST_HOT);
        log_check(1, `ST_EXT_EVT);
        log_check(2, `ST_CRIT);
        log_check(3, `ST_PWR_LIM);
        src_req[4] <= 1'b1;
        idle(4);
        rd_reg(`REG_CORE_STATUS, 64'h400, 64'h400);
        rd_reg(`REG_PKG_STATUS, 64'h800, 64'h800);
        src_req[4] <= 1'b0;
        wr_reg(`REG_PKG_STATUS, 64'h0);
        $display("test status and logs done");
        wr_reg(`REG_PKG_INTR_CTRL, 64'h8A_9400);
        valid_req <= 1'b1;
        thr(30, 64'h0, 0);
        thr(20, 64'hC0, 1);
        thr(10, 64'h3C0, 1);
        thr(30, 64'h280, 1);
        rd_reg(`REG_CORE_STATUS, 64'h801E_0000, 64'h807F_0000);
        $display("test thresholds done");
        ev(64'h1, 64'h0, 0, 1'b1, 1, 0);
        ev(64'h1, 64'h0, 0, 1'b0, 0, 0);
        ev(64'h2, 64'h0, 0, 1'b1, 0, 0);
        ev(64'h2, 64'h0, 0, 1'b0, 1, 0);
        ev(64'h4, 64'h0, 1, 1'b1, 0, 0);
        ev(64'h4, 64'h0, 1, 1'b0, 0, 0);
        bidir = 1'b1;
        ev(64'h4, 64'h0, 1, 1'b1, 1, 0);
        ev(64'h10, 64'h0, 2, 1'b1, 1, 0);
        ev(64'h100_0000, 64'h0, 3, 1'b1, 1, 0);
        ev(64'h0, 64'h100_0000, 4, 1'b1, 0, 1);
        ev(64'h0, 64'h0, 2, 1'b0, 0, 0);
        $display("test interrupts done");
        print_verdict();
    end
endmodule
